/* File: ptd_defines.vh */
/*
 * Shared constants of the target-side command and address decoder:
 * bus command codes, decoder state codes, field positions and timing.
 * Assumes a 32-bit bus sampled on the rising clock edge.
 */
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

// bus command codes as they appear on the command lines
`define PTD_CMD_IO_RD    4'h2
`define PTD_CMD_IO_WR    4'h3
`define PTD_CMD_MEM_RD   4'h6
`define PTD_CMD_MEM_WR   4'h7
`define PTD_CMD_CFG_RD   4'ha
`define PTD_CMD_CFG_WR   4'hb

// address space codes reported to the local side
`define PTD_SPACE_IO     2'h0
`define PTD_SPACE_MEM    2'h1
`define PTD_SPACE_CFG    2'h2

// decoder states
`define PTD_ST_IDLE      3'h0
`define PTD_ST_DECODE    3'h1
`define PTD_ST_DATA      3'h2
`define PTD_ST_STOP      3'h3
`define PTD_ST_TURN      3'h4

// field positions in the address word
`define PTD_CFG_FUNC_HI  10
`define PTD_CFG_FUNC_LO  8
`define PTD_CFG_REG_HI   7
`define PTD_CFG_REG_LO   2
`define PTD_CFG_TYPE0    2'h0
`define PTD_BURST_LINEAR 2'h0

// device select timing class reported in status (medium)
`define PTD_DEVSEL_TIMING 2'h1

// defaults for the decoded windows
`define PTD_IO_BASE_RST  32'h0000_1000
`define PTD_MEM_BASE_RST 32'h8000_0000

`endif

/* File: ptd_parity.v */
/*
 * Even parity generator over a vector of any width.
 * Pure combinational; the caller registers the result where needed.
 */
module ptd_parity #(
	parameter WIDTH = 36
) (
	input  wire [WIDTH-1:0] bits,
	output wire             parity
);

	// parity bit that makes the total count of ones even
	assign parity = ^bits;

endmodule // ptd_parity

/* File: ptd_pci_master.sv */
/* bus master model issuing one transaction per access() call.
   assumes nothing else drives the bus lines it owns */
module ptd_pci_master (
	input  wire logic        clk,
	input  wire logic [31:0] adOut,
	input  wire logic        adOe,
	input  wire logic        parOut,
	input  wire logic        parOe,
	input  wire logic        devselOut_n,
	input  wire logic        devselOe,
	input  wire logic        trdyOut_n,
	input  wire logic        trdyOe,
	input  wire logic        stopOut_n,
	input  wire logic        stopOe,
	output logic             frameIn_n,
	output logic             irdyIn_n,
	output logic             idsel,
	output wire logic [31:0] adIn,
	output logic      [3:0]  cbeIn_n,
	output wire logic        parIn
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////
	logic [31:0] adDrv;  // last word put on the lines
	logic        adEn;   // master owns the lines
	logic        parDrv; // lagging parity
	logic        parEn;
	logic        flip;   // corrupts the parity of the current word
	// released control lines float up to their pull-ups
	wire devsel_n = devselOe ? devselOut_n : 1'b1;
	wire trdy_n   = trdyOe ? trdyOut_n : 1'b1;
	wire stop_n   = stopOe ? stopOut_n : 1'b1;
	// released lines show the inverse so stale data never matches
	assign adIn  = adOe ? adOut : (adEn ? adDrv : ~adDrv);
	assign parIn = parOe ? parOut : (parEn ? parDrv : ~parDrv);
	initial begin
		frameIn_n = 1'b1;
		irdyIn_n = 1'b1;
		idsel = 1'b0;
		cbeIn_n = 4'hf;
		adDrv = 32'h0;
		adEn = 1'b0;
		flip = 1'b0;
	end
	// parity trails its word by one clock
	always @(posedge clk) begin
		parDrv <= ^{adDrv, cbeIn_n} ^ flip;
		parEn <= adEn;
	end
	// one transaction of nd data phases; reports transfers and stop
	task automatic access(input logic [3:0] cmd, input logic [31:0] addr,
		input logic [3:0] be, input logic sel, input logic badA,
		input logic badD, input int nd, output int xf, output int stp,
		output int dv, output logic [31:0] rd);
		int   w;
		logic hit;
		xf = 0;
		stp = 0;
		dv = 0;
		rd = 32'h0;
		@(posedge clk);
		#1;
		frameIn_n = 1'b0;
		adDrv = addr;
		adEn = 1'b1;
		cbeIn_n = cmd;
		idsel = sel;
		flip = badA;
		@(posedge clk);
		#1;
		idsel = 1'b0;
		cbeIn_n = be;
		irdyIn_n = 1'b0;
		frameIn_n = (nd == 1);
		adEn = cmd[0];
		adDrv = 32'hc3a5_0f10;
		flip = badD;
		for (w = 0; w < 12 && xf < nd && stp < 2; w++) begin
			@(posedge clk);
			hit = !trdy_n && !irdyIn_n;
			if (!devsel_n)
				dv = 1;
			if (!stop_n)
				stp = frameIn_n ? 2 : 1;
			if (hit)
				rd = adIn;
			xf = xf + hit;
			#1;
			if (hit)
				adDrv = adDrv + 32'h1;
			if (hit)
				flip = 1'b0;
			if (xf == nd - 1 || stp != 0)
				frameIn_n = 1'b1;
		end
		// frame and ready stay driven high; only data is let go
		irdyIn_n = 1'b1;
		frameIn_n = 1'b1;
		adEn = 1'b0;
		flip = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
endmodule // ptd_pci_master

/* File: ptd_sts_drv.v */
/*
 * Driver for one sustained tri-state, active-low bus signal.
 * Assumes the owner raises hold for as long as it owns the line.
 */
module ptd_sts_drv (
	input  wire clk,
	input  wire arst_n,
	input  wire assertReq,
	input  wire holdReq,
	output reg  pinOut_n,
	output reg  pinOe
);

	reg ownPrev; // owned in the previous cycle

	////////////////////////////////////////////////////////////////////
	// drive low while asserted; after ownership ends the line is driven
	// high for one more clock so a slow pull-up cannot leave it
	// floating low for the next owner
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinOut_n <= 1'b1;
			pinOe    <= 1'b0;
			ownPrev  <= 1'b0;
		end else begin
			ownPrev  <= holdReq;
			pinOut_n <= ~(assertReq & holdReq);
			pinOe    <= holdReq | ownPrev;
		end
	end

endmodule // ptd_sts_drv

/* File: ptd_target_decode.v */
/*
 * Target front end of a single-function 32-bit bus device: decodes
 * command and address, claims its own accesses with medium device
 * select timing, checks I/O byte enables and burst order, selects
 * configuration by select line and function, and flags parity errors.
 * Assumes all pin inputs are synchronous to clk (the bus clock) and
 * that a board-level resolver merges the output enables onto wires.
 */
`include "ptd_defines.vh"

module ptd_target_decode #(
	parameter [31:0] IO_BASE  = `PTD_IO_BASE_RST,
	parameter        IO_BITS  = 8,
	parameter [31:0] MEM_BASE = `PTD_MEM_BASE_RST,
	parameter        MEM_BITS = 16
) (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        frameIn_n,
	input  wire        irdyIn_n,
	input  wire        idsel,
	input  wire [31:0] adIn,
	input  wire [3:0]  cbeIn_n,
	input  wire        parIn,
	output reg  [31:0] adOut,
	output reg         adOe,
	output reg         parOut,
	output reg         parOe,
	output wire        devselOut_n,
	output wire        devselOe,
	output wire        trdyOut_n,
	output wire        trdyOe,
	output wire        stopOut_n,
	output wire        stopOe,
	output wire        perrOut_n,
	output wire        perrOe,
	output reg         serrOut_n,
	output reg         serrOe,
	input  wire        localReady,
	input  wire [31:0] rdData,
	output reg         hitStrobe,
	output reg  [1:0]  hitSpace,
	output reg  [31:0] hitAddr,
	output reg         hitWrite,
	output reg         xferStrobe,
	output reg  [31:0] xferData,
	output reg  [3:0]  xferBe,
	output reg         addrParErr,
	output reg         dataParErr
);

	////////////////////////////////////////////////////////////////////
	// state and latched address phase

	reg  [2:0]  state;      // decoder state
	reg  [2:0]  next_state; // next decoder state
	reg  [31:0] addrReg;    // address captured in the address phase
	reg  [3:0]  cmdReg;     // command captured in the address phase
	reg         idselReg;   // config select captured with the address
	reg         lastIdle;   // bus was idle in the previous cycle
	reg  [31:0] lastAd;     // lines of the previous cycle, for parity
	reg  [3:0]  lastCbe;    // command/enables of the previous cycle
	reg         wrXferPrev; // a write transfer ended last cycle
	reg         nonLinear;  // claimed burst uses an unsupported order
	reg         isWrite;    // claimed access is a write
	reg  [29:0] dwAddr;     // running doubleword address of a burst

	wire        chkParity;  // parity of the previous cycle's lines
	wire        genParity;  // parity of what we drive now
	wire        parBad;     // previous cycle's parity does not match
	wire        addrPhase;  // first clock of a new transaction
	wire        xfer;       // data transfer this edge

	// the command lines hold the command raw, not inverted
	wire [3:0]  cmd = cbeIn_n;

	// sampled at every rising edge only
	assign addrPhase = ~frameIn_n & lastIdle;
	assign xfer      = ~irdyIn_n & ~trdyOut_n;
	assign parBad    = chkParity ^ parIn;

	ptd_parity #(.WIDTH(36)) u_chk (
		.bits   ({lastAd, lastCbe}),
		.parity (chkParity)
	);

	ptd_parity #(.WIDTH(36)) u_gen (
		.bits   ({adOut, cbeIn_n}),
		.parity (genParity)
	);

	////////////////////////////////////////////////////////////////////
	// decode of the captured address phase, judged in the turnaround
	// cycle when byte enables and address parity are both on the bus

	reg ioCmd;   // I/O read or write
	reg memCmd;  // plain memory read or write
	reg cfgCmd;  // configuration read or write
	reg ioBeOk;  // byte enables legal for the starting byte
	reg claim;   // this access is ours

	// unsupported codes fall through as not addressed
	always @* begin
		ioCmd  = (cmdReg == `PTD_CMD_IO_RD) ||
			(cmdReg == `PTD_CMD_IO_WR);
		memCmd = (cmdReg == `PTD_CMD_MEM_RD) ||
			(cmdReg == `PTD_CMD_MEM_WR);
		cfgCmd = (cmdReg == `PTD_CMD_CFG_RD) ||
			(cmdReg == `PTD_CMD_CFG_WR);
	end

	// starting byte against enables; all-off is always legal
	always @* begin
		case (addrReg[1:0])
			2'h0: ioBeOk = 1'b1;
			2'h1: ioBeOk = (cbeIn_n[1:0] == 2'h1) ||
				(cbeIn_n == 4'hf);
			2'h2: ioBeOk = (cbeIn_n[2:0] == 3'h3) ||
				(cbeIn_n == 4'hf);
			2'h3: ioBeOk = (cbeIn_n == 4'h7) || (cbeIn_n == 4'hf);
			default: ioBeOk = 1'b0;
		endcase
	end

	// a corrupted address is never claimed: it may not be ours
	always @* begin
		claim = 1'b0;
		if (!parBad) begin
			if (ioCmd)
				claim = ioBeOk && (addrReg[31:IO_BITS] ==
					IO_BASE[31:IO_BITS]);
			else if (memCmd)
				claim = addrReg[31:MEM_BITS] ==
					MEM_BASE[31:MEM_BITS];
			else if (cfgCmd)
				claim = idselReg &&
					(addrReg[1:0] == `PTD_CFG_TYPE0) &&
					(addrReg[`PTD_CFG_FUNC_HI:`PTD_CFG_FUNC_LO]
					== 3'h0);
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always @* begin
		next_state = state;
		case (state)
			`PTD_ST_IDLE: begin
				if (addrPhase)
					next_state = `PTD_ST_DECODE;
			end
			// one wait clock gives medium select timing
			`PTD_ST_DECODE: begin
				if (claim)
					next_state = `PTD_ST_DATA;
				else
					next_state = `PTD_ST_IDLE;
			end
			`PTD_ST_DATA: begin
				if (xfer && frameIn_n)
					next_state = `PTD_ST_TURN;
				else if (xfer && nonLinear)
					next_state = `PTD_ST_STOP;
			end
			// hold stop until the master drops frame
			`PTD_ST_STOP: begin
				if (frameIn_n)
					next_state = `PTD_ST_TURN;
			end
			`PTD_ST_TURN: next_state = `PTD_ST_IDLE;
			default: next_state = `PTD_ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// control line requests, fed from next state (perrReq from wrXferPrev)
	// so the select, ready and stop driver flops change on the same edge as the state

	wire ownTarget = (next_state == `PTD_ST_DATA) ||
		(next_state == `PTD_ST_STOP);
	wire trdyReq   = (next_state == `PTD_ST_DATA) && localReady &&
		!(xfer && nonLinear);
	wire stopReq   = (next_state == `PTD_ST_STOP);
	wire perrReq   = wrXferPrev && parBad;

	// select asserted for our own access
	ptd_sts_drv u_devsel (
		.clk       (clk),
		.arst_n    (arst_n),
		.assertReq (ownTarget),
		.holdReq   (ownTarget),
		.pinOut_n  (devselOut_n),
		.pinOe     (devselOe)
	);

	// ready only while the local side can finish the phase
	ptd_sts_drv u_trdy (
		.clk       (clk),
		.arst_n    (arst_n),
		.assertReq (trdyReq),
		.holdReq   (ownTarget),
		.pinOut_n  (trdyOut_n),
		.pinOe     (trdyOe)
	);

	ptd_sts_drv u_stop (
		.clk       (clk),
		.arst_n    (arst_n),
		.assertReq (stopReq),
		.holdReq   (ownTarget),
		.pinOut_n  (stopOut_n),
		.pinOe     (stopOe)
	);

	// one clock low then one clock high, then released
	ptd_sts_drv u_perr (
		.clk       (clk),
		.arst_n    (arst_n),
		.assertReq (perrReq),
		.holdReq   (perrReq),
		.pinOut_n  (perrOut_n),
		.pinOe     (perrOe)
	);

	////////////////////////////////////////////////////////////////////
	// state, capture and parity history

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= `PTD_ST_IDLE;
			addrReg    <= 32'h0000_0000;
			cmdReg     <= 4'h0;
			idselReg   <= 1'b0;
			lastIdle   <= 1'b0;
			lastAd     <= 32'h0000_0000;
			lastCbe    <= 4'h0;
			wrXferPrev <= 1'b0;
			nonLinear  <= 1'b0;
			isWrite    <= 1'b0;
		end else begin
			state    <= next_state;
			lastIdle <= frameIn_n & irdyIn_n;
			lastAd   <= adIn;
			lastCbe  <= cbeIn_n;
			// only write data parity is ours to check
			wrXferPrev <= (state == `PTD_ST_DATA ||
				state == `PTD_ST_STOP) && xfer && isWrite;
			if (addrPhase && state == `PTD_ST_IDLE) begin
				addrReg  <= adIn;
				cmdReg   <= cmd;
				idselReg <= idsel;
			end
			if (state == `PTD_ST_DECODE) begin
				isWrite   <= cmdReg[0];
				// order bits only matter for memory
				nonLinear <= memCmd &&
					(addrReg[1:0] != `PTD_BURST_LINEAR);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data and its parity; parity trails the data by one clock

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adOut  <= 32'h0000_0000;
			adOe   <= 1'b0;
			parOut <= 1'b0;
			parOe  <= 1'b0;
		end else begin
			adOe   <= ownTarget && !cmdReg[0];
			parOut <= genParity;
			parOe  <= adOe;
			// keep the word steady while ready waits on the master
			if (trdyOut_n || xfer)
				adOut <= rdData;
		end
	end

	////////////////////////////////////////////////////////////////////
	// local side reports and error flags

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hitStrobe  <= 1'b0;
			hitSpace   <= `PTD_SPACE_IO;
			hitAddr    <= 32'h0000_0000;
			hitWrite   <= 1'b0;
			xferStrobe <= 1'b0;
			xferData   <= 32'h0000_0000;
			xferBe     <= 4'h0;
			addrParErr <= 1'b0;
			dataParErr <= 1'b0;
			serrOut_n  <= 1'b1;
			serrOe     <= 1'b0;
			dwAddr     <= 30'h0000_0000;
		end else begin
			hitStrobe  <= (state == `PTD_ST_DECODE) && claim;
			xferStrobe <= (state == `PTD_ST_DATA) && xfer;
			// open drain: drive low one clock, otherwise float
			addrParErr <= (state == `PTD_ST_DECODE) && parBad;
			serrOe     <= (state == `PTD_ST_DECODE) && parBad;
			serrOut_n  <= ~((state == `PTD_ST_DECODE) &&
				parBad);
			dataParErr <= perrReq;
			if (state == `PTD_ST_DECODE) begin
				hitWrite <= cmdReg[0];
				dwAddr   <= addrReg[31:2];
				if (ioCmd) begin
					hitSpace <= `PTD_SPACE_IO;
					hitAddr  <= addrReg;
				end else if (memCmd) begin
					hitSpace <= `PTD_SPACE_MEM;
					hitAddr  <= {addrReg[31:2], 2'h0};
				end else begin
					hitSpace <= `PTD_SPACE_CFG;
					hitAddr  <= {24'h000000,
						addrReg[`PTD_CFG_REG_HI:`PTD_CFG_REG_LO],
						2'h0};
				end
			end
			if (state == `PTD_ST_DATA && xfer) begin
				xferData <= isWrite ? adIn : adOut;
				xferBe   <= ~cbeIn_n;
				hitAddr  <= {dwAddr, 2'h0};
				// linear increment for the next phase
				dwAddr   <= dwAddr + 30'h0000_0001;
			end
		end
	end

endmodule // ptd_target_decode

/* File: ptd_target_decode_checker.sv */
/* concurrent checks on the target decoder pins.
   assumes it is bound to the decoder and sees only its ports */
module ptd_target_decode_checker (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        frameIn_n,
	input wire logic        irdyIn_n,
	input wire logic        idsel,
	input wire logic [31:0] adIn,
	input wire logic [3:0]  cbeIn_n,
	input wire logic [31:0] adOut,
	input wire logic        parOut,
	input wire logic        parOe,
	input wire logic        devselOut_n,
	input wire logic        devselOe,
	input wire logic        trdyOut_n,
	input wire logic        trdyOe,
	input wire logic        perrOut_n,
	input wire logic        perrOe,
	input wire logic        serrOut_n,
	input wire logic        serrOe,
	input wire logic        addrParErr,
	input wire logic        dataParErr
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// address phase: frame falls after an idle clock
	sequence sAddr;
		$past(frameIn_n) && $past(irdyIn_n) && !frameIn_n;
	endsequence
	// no select activity at all for four clocks
	sequence sQuiet;
		!devselOe [*4];
	endsequence
	a_par_even: assert property (
		parOe |-> parOut == ^{$past(adOut), $past(cbeIn_n)})
		else $error("read parity not even");
	a_devsel_park: assert property (
		$fell(devselOe) |-> $past(devselOut_n))
		else $error("select released while low");
	a_trdy_park: assert property (
		$fell(trdyOe) |-> $past(trdyOut_n))
		else $error("ready released while low");
	a_cmd_ignore: assert property (
		sAddr ##0 (cbeIn_n[3:1] inside {3'h0, 3'h2, 3'h4, 3'h6, 3'h7})
		|=> sQuiet)
		else $error("unsupported command claimed");
	a_cfg_select: assert property (
		sAddr ##0 (cbeIn_n[3:1] == 3'h5 && (!idsel
		|| adIn[1:0] != 2'h0 || adIn[10:8] != 3'h0)) |=> sQuiet)
		else $error("foreign config access claimed");
	a_io_bytes: assert property (
		sAddr ##0 (cbeIn_n[3:1] == 3'h1 && adIn[1:0] == 2'h3)
		##1 (cbeIn_n != 4'h7 && cbeIn_n != 4'hf) |=> !devselOe [*3])
		else $error("illegal io byte enables claimed");
	a_devsel_medium: assert property (
		$rose(devselOe) |-> !devselOut_n && !$past(frameIn_n, 2)
		&& $past(frameIn_n, 3))
		else $error("select not at medium timing");
	a_trdy_sel: assert property (
		trdyOe && !trdyOut_n |-> devselOe && !devselOut_n)
		else $error("ready without select");
	a_serr_pulse: assert property (
		serrOe |-> !serrOut_n && addrParErr ##1 !serrOe)
		else $error("system error pulse malformed");
	a_perr_pulse: assert property (
		dataParErr |-> perrOe && !perrOut_n ##1 (perrOe && perrOut_n))
		else $error("parity error pulse malformed");
endmodule // ptd_target_decode_checker

bind ptd_target_decode ptd_target_decode_checker chk_u (
	.clk, .arst_n, .frameIn_n, .irdyIn_n, .idsel, .adIn, .cbeIn_n,
	.adOut, .parOut, .parOe, .devselOut_n, .devselOe, .trdyOut_n,
	.trdyOe, .perrOut_n, .perrOe, .serrOut_n, .serrOe, .addrParErr,
	.dataParErr);

/* File: test_ptd_target_decode.sv */
/* self-checking bench: a master model issues transactions and the
   bench judges claim and local strobes. checker is bound separately */
`include "ptd_defines.vh"
module test_ptd_target_decode;
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////
	localparam logic [31:0] IOB  = `PTD_IO_BASE_RST;
	localparam logic [31:0] MEMB = `PTD_MEM_BASE_RST;
	logic        clk, arst_n, localReady;
	logic [31:0] rdData, rd, gAddr, gData;
	logic [1:0]  gSpace;
	logic [3:0]  gBe;
	logic        gWrite;
	wire         frameIn_n, irdyIn_n, idsel, parIn, adOe, parOut, parOe;
	wire  [31:0] adIn, adOut, hitAddr, xferData;
	wire  [3:0]  cbeIn_n, xferBe;
	wire  [1:0]  hitSpace;
	wire         devselOut_n, devselOe, trdyOut_n, trdyOe, stopOut_n;
	wire         stopOe, perrOut_n, perrOe, serrOut_n, serrOe, hitStrobe;
	wire         hitWrite, xferStrobe, addrParErr, dataParErr;
	int          n_fail = 0, check_count = 0, xf, stp, dv;
	int          nHit, nXfer, nAp, nDp;
	ptd_target_decode dut_u (.clk, .arst_n, .frameIn_n, .irdyIn_n, .idsel,
		.adIn, .cbeIn_n, .parIn, .adOut, .adOe, .parOut, .parOe,
		.devselOut_n, .devselOe, .trdyOut_n, .trdyOe, .stopOut_n, .stopOe,
		.perrOut_n, .perrOe, .serrOut_n, .serrOe, .localReady, .rdData,
		.hitStrobe, .hitSpace, .hitAddr, .hitWrite, .xferStrobe, .xferData,
		.xferBe, .addrParErr, .dataParErr);
	ptd_pci_master mst_u (.clk, .adOut, .adOe, .parOut, .parOe,
		.devselOut_n, .devselOe, .trdyOut_n, .trdyOe, .stopOut_n, .stopOe,
		.frameIn_n, .irdyIn_n, .idsel, .adIn, .cbeIn_n, .parIn);
	// counts local strobes and keeps what they carried
	always @(posedge clk) begin
		if (hitStrobe === 1'b1) begin
			nHit++;
			gSpace = hitSpace;
			gAddr = hitAddr;
			gWrite = hitWrite;
		end
		if (xferStrobe === 1'b1) begin
			nXfer++;
			gData = xferData;
			gBe = xferBe;
		end
		if (addrParErr === 1'b1)
			nAp++;
		if (dataParErr === 1'b1)
			nDp++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [3:0] c, input logic [31:0] a,
		input logic [3:0] be, input logic s, input logic ba,
		input logic bd, input int nd);
		nHit = 0;
		nXfer = 0;
		nAp = 0;
		nDp = 0;
		mst_u.access(c, a, be, s, ba, bd, nd, xf, stp, dv, rd);
	endtask
	// every command code, each at an address that would hit its space
	task automatic t_cmds;
		logic [3:0]  c;
		logic [31:0] a;
		logic        ok;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			ok = c[3:1] == 3'h1 || c[3:1] == 3'h3 || c[3:1] == 3'h5;
			a = c[3] ? 32'h0000_f054 : (c[2] ? MEMB + 32'h24 : IOB + 32'h25);
			run(c, a, 4'h1, c[3], 1'b0, 1'b0, 1);
			check(nHit, ok);
			check(dv, ok);
			check(xf, ok);
			if (ok) begin
				check(gSpace, c[3] ? `PTD_SPACE_CFG :
					(c[2] ? `PTD_SPACE_MEM : `PTD_SPACE_IO));
				check(gAddr, c[3] ? 32'h54 : a);
				check(gWrite, c[0]);
				if (c[0])
					check(gData, 32'hc3a5_0f10);
				if (c[0])
					check(gBe, 4'he);
				if (!c[0])
					check(rd, rdData);
			end
		end
	endtask
	// byte enables against the low address bits, legal and not
	task automatic t_iobe;
		logic [1:0] off [6] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
		logic [3:0] be [6] = '{4'h7, 4'h3, 4'h3, 4'h5, 4'hf, 4'he};
		for (int i = 0; i < 6; i++) begin
			run(`PTD_CMD_IO_WR, IOB + off[i], be[i], 1'b0, 1'b0, 1'b0, 1);
			check(nHit, i % 2 == 0);
		end
	endtask
	// select low, type 1, and a nonzero function are all refused
	task automatic t_cfg;
		logic [31:0] a [3] = '{32'h54, 32'h55, 32'h154};
		for (int i = 0; i < 3; i++) begin
			run(`PTD_CMD_CFG_WR, a[i], 4'h0, i != 0, 1'b0, 1'b0, 1);
			check(nHit + dv, 0);
		end
	endtask
	// two-phase bursts: odd order stops after one, linear runs on
	task automatic t_burst;
		run(`PTD_CMD_MEM_WR, MEMB + 32'h41, 4'h0, 1'b0, 1'b0, 1'b0, 2);
		check(xf, 1);
		check(stp != 0, 1);
		check(nXfer, 1);
		run(`PTD_CMD_MEM_WR, MEMB + 32'h40, 4'h0, 1'b0, 1'b0, 1'b0, 2);
		check(xf, 2);
		check(stp, 0);
		check(nXfer, 2);
		check(gAddr, MEMB + 32'h40);
		check(hitAddr, MEMB + 32'h44);
	endtask
	// reset in mid-run clears the local reports and the select pin
	task automatic t_rst;
		arst_n = 1'b0;
		@(posedge clk);
		check(hitAddr, 32'h0000_0000);
		check(hitSpace, `PTD_SPACE_IO);
		check(hitWrite, 1'b0);
		check(devselOe, 1'b0);
		#1 arst_n = 1'b1;
	endtask
	// local side late: ready must wait, and the word shown is the new one
	task automatic t_wait;
		localReady = 1'b0;
		fork
			run(`PTD_CMD_MEM_RD, MEMB + 32'h8, 4'h0, 1'b0, 1'b0, 1'b0, 1);
			begin
				repeat (4) @(posedge clk);
				#1;
				localReady = 1'b1;
				rdData = 32'h1e87_5a3c;
			end
		join
		check(xf, 1);
		check(dv, 1);
		check(rd, 32'h1e87_5a3c);
		check(gData, 32'h1e87_5a3c);
		check(nXfer, 1);
	endtask
	// bad address parity is refused and flagged; bad data flagged
	task automatic t_par;
		run(`PTD_CMD_MEM_WR, MEMB, 4'h0, 1'b0, 1'b1, 1'b0, 1);
		check(nHit, 0);
		check(nAp, 1);
		run(`PTD_CMD_MEM_WR, MEMB, 4'h0, 1'b0, 1'b0, 1'b1, 1);
		check(nDp, 1);
		check(nAp, 0);
	endtask
	task automatic stop_test;
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		arst_n = 1'b0;
		localReady = 1'b1;
		rdData = 32'h6b2d_9e41;
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clk);
		t_cmds;
		t_iobe;
		t_cfg;
		t_burst;
		t_rst;
		t_wait;
		t_par;
		stop_test;
	end
endmodule // test_ptd_target_decode
